// [rtl/sdm_pkg.sv]
// Shared constants for the mode-zero burst link
package sdm_pkg;
    // ----------------------------------------
    // Widths and clock period
    // ----------------------------------------
    localparam int MR_W = 19;
    localparam int DQ_W = 4;
    localparam int BEATS = 8;
    localparam int CLK_NS = 40;
    // ----------------------------------------
    // Mode word fields
    // ----------------------------------------
    localparam int BL_LSB = 0;
    localparam int CL_EXT_BIT = 2;
    localparam int BT_BIT = 3;
    localparam int CL_LSB = 4;
    localparam int DLL_BIT = 8;
    localparam int WR_LSB = 9;
    localparam int PD_BIT = 12;
    localparam int CHOP_BIT = 12;
    localparam logic [18:0] RSV_MASK = 19'h4e080;
    localparam logic [18:0] MODE_RST = 19'h00000;
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_CHOP4 = 2'h2;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int LOCK_CYC = 512;
    localparam int MOD_CYC = 12;
    localparam int XPDLL_CYC = 10;
    localparam int XP_CYC = 3;
    localparam int T_WR_NS = 15;
    localparam int WR_CYC = (T_WR_NS + CLK_NS - 1) / CLK_NS;
    // ----------------------------------------
    // Commands and controller registers
    // ----------------------------------------
    typedef enum logic [1:0] {
        CMD_NOP = 2'h0,
        CMD_MRS = 2'h1,
        CMD_RD = 2'h2,
        CMD_WR = 2'h3
    } sdm_cmd_t;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_MODE = 3'h1;
    localparam logic [2:0] REG_ADDR = 3'h2;
    localparam logic [2:0] REG_WDATA = 3'h3;
    localparam logic [2:0] REG_RDATA = 3'h4;

    // Latency code, bit 2 extends bits 6:4
    function automatic logic [3:0] cl_decode(input logic [3:0] c);
        case (c)
            4'h2: cl_decode = 4'h5;
            4'h4: cl_decode = 4'h6;
            4'h6: cl_decode = 4'h7;
            4'h8: cl_decode = 4'h8;
            4'ha: cl_decode = 4'h9;
            4'hc: cl_decode = 4'ha;
            4'he: cl_decode = 4'hb;
            4'h1: cl_decode = 4'hc;
            4'h3: cl_decode = 4'hd;
            4'h5: cl_decode = 4'he;
            default: cl_decode = 4'h5;
        endcase
    endfunction : cl_decode

    function automatic logic [3:0] wr_decode(input logic [2:0] c);
        case (c)
            3'h1: wr_decode = 4'h5;
            3'h2: wr_decode = 4'h6;
            3'h3: wr_decode = 4'h7;
            3'h4: wr_decode = 4'h8;
            3'h5: wr_decode = 4'ha;
            default: wr_decode = 4'hc;
        endcase
    endfunction : wr_decode

    function automatic logic [2:0] wr_encode(input int cyc);
        if (cyc <= 5) wr_encode = 3'h1;
        else if (cyc == 6) wr_encode = 3'h2;
        else if (cyc == 7) wr_encode = 3'h3;
        else if (cyc == 8) wr_encode = 3'h4;
        else if (cyc <= 10) wr_encode = 3'h5;
        else wr_encode = 3'h6;
    endfunction : wr_encode
endpackage : sdm_pkg

// [rtl/sdm_link_if.sv]
// Command, address and data link between controller and memory
`timescale 1ns/1ns
interface sdm_link_if;
    logic mem_rst_n;
    logic cke;
    logic [1:0] cmd;
    logic [2:0] bank;
    logic [18:0] addr;
    logic [3:0] dq_ctl;
    logic dq_ctl_oe_n;
    logic [3:0] dq_mem;
    logic dq_mem_oe_n;
    logic dqs_mem;
    logic dqs_mem_oe_n;

    modport ctl (
        output mem_rst_n, cke, cmd, bank, addr, dq_ctl, dq_ctl_oe_n,
        input dq_mem, dq_mem_oe_n, dqs_mem, dqs_mem_oe_n
    );
    modport mem (
        input mem_rst_n, cke, cmd, bank, addr, dq_ctl, dq_ctl_oe_n,
        output dq_mem, dq_mem_oe_n, dqs_mem, dqs_mem_oe_n
    );
endinterface : sdm_link_if

// [rtl/sdm_mem.sv]
// Memory end: mode word zero and the bursts it selects
`timescale 1ns/1ns
module sdm_mem #(
    parameter int COL_W = 6
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link
    sdm_link_if.mem link,
    // Status
    output logic o_loop_locked,
    output logic o_loop_running,
    output logic [3:0] o_read_latency,
    output logic [3:0] o_write_recovery,
    output logic o_interleaved
);
    if (COL_W < 3 || COL_W > 12) begin : g_bad_col
        $error("sdm_mem: COL_W out of range");
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RWAIT = 2'b01,
        ST_RBURST = 2'b11,
        ST_WBURST = 2'b10
    } sdm_mst_t;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic [18:0] mode_config_zero_reg;
    logic clr_n;
    logic mrs_now;
    logic rd_now;
    logic wr_now;
    logic chop_now;
    logic [1:0] bl_code;
    assign clr_n = link.mem_rst_n;
    assign bl_code = mode_config_zero_reg[sdm_pkg::BL_LSB+1:sdm_pkg::BL_LSB];
    assign mrs_now = link.cke && link.cmd == sdm_pkg::CMD_MRS && link.bank == 3'h0;
    assign rd_now = link.cke && link.cmd == sdm_pkg::CMD_RD;
    assign wr_now = link.cke && link.cmd == sdm_pkg::CMD_WR;

    always_comb begin
        case (bl_code)
            sdm_pkg::BL_FIXED8: chop_now = 1'b0;
            sdm_pkg::BL_CHOP4: chop_now = 1'b1;
            sdm_pkg::BL_OTF: chop_now = !link.addr[sdm_pkg::CHOP_BIT];
            default: chop_now = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Mode word
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst || !clr_n) begin
            mode_config_zero_reg <= sdm_pkg::MODE_RST;
        end else if (mrs_now) begin
            mode_config_zero_reg <= link.addr;
        end else begin
            mode_config_zero_reg[sdm_pkg::DLL_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_read_latency <= 4'h5;
            o_write_recovery <= 4'hc;
            o_interleaved <= 1'b0;
        end else begin
            o_read_latency <= sdm_pkg::cl_decode({mode_config_zero_reg[6:4],
                mode_config_zero_reg[sdm_pkg::CL_EXT_BIT]});
            o_write_recovery <= sdm_pkg::wr_decode(mode_config_zero_reg[11:9]);
            o_interleaved <= mode_config_zero_reg[sdm_pkg::BT_BIT];
        end
    end

    // ----------------------------------------
    // Loop and sleep
    // ----------------------------------------
    logic [9:0] lock_cnt_reg;
    logic sleep_reg;
    always_ff @(posedge i_clk) begin
        if (i_rst || !clr_n) begin
            sleep_reg <= 1'b0;
            o_loop_running <= 1'b1;
        end else if (!link.cke) begin
            sleep_reg <= 1'b1;
            o_loop_running <= mode_config_zero_reg[sdm_pkg::PD_BIT];
        end else begin
            sleep_reg <= 1'b0;
            o_loop_running <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || !clr_n) begin
            lock_cnt_reg <= 10'h000;
        end else if (mrs_now && link.addr[sdm_pkg::DLL_BIT]) begin
            lock_cnt_reg <= 10'(sdm_pkg::LOCK_CYC);
        end else if (sleep_reg && link.cke && !o_loop_running) begin
            lock_cnt_reg <= 10'(sdm_pkg::XPDLL_CYC);
        end else if (lock_cnt_reg != 10'h000 && link.cke) begin
            lock_cnt_reg <= lock_cnt_reg - 10'h001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_loop_locked <= 1'b0;
        end else begin
            o_loop_locked <= o_loop_running && lock_cnt_reg == 10'h000;
        end
    end

    // ----------------------------------------
    // Burst engine
    // ----------------------------------------
    sdm_mst_t st_reg;
    logic [3:0] wait_reg;
    logic [2:0] beat_reg;
    logic chop_reg;
    logic [COL_W-1:0] start_reg;
    logic [COL_W-1:0] rd_col;
    logic [COL_W-1:0] wr_col;
    logic [sdm_pkg::DQ_W-1:0] mem_reg [2**COL_W];

    // Column of the current beat, held inside its aligned block
    always_comb begin
        rd_col = start_reg;
        rd_col[2] = start_reg[2] ^ (beat_reg[2] & !chop_reg);
        if (o_interleaved) begin
            rd_col[1:0] = start_reg[1:0] ^ beat_reg[1:0];
        end else begin
            rd_col[1:0] = start_reg[1:0] + beat_reg[1:0];
        end
        wr_col = start_reg;
        wr_col[2] = chop_reg ? start_reg[2] : beat_reg[2];
        wr_col[1:0] = beat_reg[1:0];
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || !clr_n) begin
            st_reg <= ST_IDLE;
            wait_reg <= 4'h0;
            beat_reg <= 3'h0;
            chop_reg <= 1'b0;
            start_reg <= '0;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    beat_reg <= 3'h0;
                    chop_reg <= chop_now;
                    start_reg <= link.addr[COL_W-1:0];
                    if (rd_now) begin
                        wait_reg <= o_read_latency - 4'h1;
                        st_reg <= ST_RWAIT;
                    end else if (wr_now) begin
                        st_reg <= ST_WBURST;
                    end
                end
                ST_RWAIT: begin
                    wait_reg <= wait_reg - 4'h1;
                    if (wait_reg == 4'h1) begin
                        st_reg <= ST_RBURST;
                    end
                end
                ST_RBURST, ST_WBURST: begin
                    beat_reg <= beat_reg + 3'h1;
                    if (beat_reg == 3'h7) begin
                        st_reg <= ST_IDLE;
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (st_reg == ST_WBURST && !(chop_reg && beat_reg[2])) begin
            mem_reg[wr_col] <= link.dq_ctl;
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst || !clr_n) begin
            link.dq_mem <= 4'h0;
            link.dq_mem_oe_n <= 1'b1;
            link.dqs_mem <= 1'b0;
            link.dqs_mem_oe_n <= 1'b1;
        end else if (st_reg == ST_RBURST && !(chop_reg && beat_reg[2])) begin
            link.dq_mem <= mem_reg[rd_col];
            link.dq_mem_oe_n <= 1'b0;
            link.dqs_mem <= !beat_reg[0];
            link.dqs_mem_oe_n <= 1'b0;
        end else begin
            link.dq_mem <= 4'h0;
            link.dq_mem_oe_n <= 1'b1;
            link.dqs_mem <= 1'b0;
            link.dqs_mem_oe_n <= 1'b1;
        end
    end
endmodule : sdm_mem

// [rtl/sdm_ctl.sv]
// Controller end: register port, mode setting, bursts, sleep
`timescale 1ns/1ns
module sdm_ctl (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [2:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Link
    sdm_link_if.ctl link
);
    typedef enum logic [2:0] {
        CS_IDLE = 3'b000,
        CS_HOLD = 3'b001,
        CS_RD = 3'b011,
        CS_WR = 3'b010,
        CS_SLEEP = 3'b110
    } sdm_cst_t;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    sdm_cst_t st_reg;
    logic [18:0] mode_reg;
    logic [12:0] addr_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic [9:0] lock_reg;
    logic [4:0] hold_reg;
    logic [3:0] beat_reg;
    logic chop_reg;
    logic [18:0] mode_clean;
    logic go;
    logic chop_cmd;

    assign go = i_wr && i_addr == sdm_pkg::REG_CTRL;
    always_comb begin
        mode_clean = mode_reg & ~sdm_pkg::RSV_MASK;
        mode_clean[11:9] = sdm_pkg::wr_encode(sdm_pkg::WR_CYC);
        case (mode_reg[1:0])
            sdm_pkg::BL_CHOP4: chop_cmd = 1'b1;
            sdm_pkg::BL_OTF: chop_cmd = !addr_reg[sdm_pkg::CHOP_BIT];
            default: chop_cmd = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            mode_reg <= sdm_pkg::MODE_RST;
            addr_reg <= 13'h0000;
            wdata_reg <= 32'h00000000;
        end else if (i_wr) begin
            case (i_addr)
                sdm_pkg::REG_MODE: mode_reg <= i_wdata[18:0];
                sdm_pkg::REG_ADDR: addr_reg <= i_wdata[12:0];
                sdm_pkg::REG_WDATA: wdata_reg <= i_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            case (i_addr)
                sdm_pkg::REG_CTRL: o_rdata <= {29'h0, lock_reg != 10'h0,
                    st_reg == CS_SLEEP, st_reg != CS_IDLE};
                sdm_pkg::REG_MODE: o_rdata <= {13'h0, mode_reg};
                sdm_pkg::REG_ADDR: o_rdata <= {19'h0, addr_reg};
                sdm_pkg::REG_WDATA: o_rdata <= wdata_reg;
                sdm_pkg::REG_RDATA: o_rdata <= rdata_reg;
                default: o_rdata <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg <= CS_IDLE;
            lock_reg <= 10'h000;
            hold_reg <= 5'h00;
            beat_reg <= 4'h0;
            chop_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            link.mem_rst_n <= 1'b0;
            link.cke <= 1'b1;
            link.cmd <= sdm_pkg::CMD_NOP;
            link.bank <= 3'h0;
            link.addr <= 19'h00000;
            link.dq_ctl <= 4'h0;
            link.dq_ctl_oe_n <= 1'b1;
        end else begin
            link.mem_rst_n <= 1'b1;
            link.cmd <= sdm_pkg::CMD_NOP;
            link.dq_ctl_oe_n <= 1'b1;
            if (lock_reg != 10'h000 && st_reg != CS_SLEEP) begin
                lock_reg <= lock_reg - 10'h001;
            end
            case (st_reg)
                CS_IDLE: begin
                    beat_reg <= 4'h0;
                    chop_reg <= chop_cmd;
                    if (go && i_wdata[0]) begin
                        link.cmd <= sdm_pkg::CMD_MRS;
                        link.bank <= 3'h0;
                        link.addr <= mode_clean;
                        hold_reg <= 5'(sdm_pkg::MOD_CYC);
                        if (mode_reg[sdm_pkg::DLL_BIT]) begin
                            lock_reg <= 10'(sdm_pkg::LOCK_CYC);
                        end
                        st_reg <= CS_HOLD;
                    end else if (go && i_wdata[1] && lock_reg == 10'h000) begin
                        link.cmd <= sdm_pkg::CMD_RD;
                        link.addr <= {6'h00, addr_reg};
                        st_reg <= CS_RD;
                    end else if (go && i_wdata[2]) begin
                        link.cmd <= sdm_pkg::CMD_WR;
                        link.addr <= {6'h00, addr_reg};
                        st_reg <= CS_WR;
                    end else if (go && i_wdata[3]) begin
                        link.cke <= 1'b0;
                        st_reg <= CS_SLEEP;
                    end
                end
                CS_HOLD: begin
                    hold_reg <= hold_reg - 5'h01;
                    if (hold_reg <= 5'h01) begin
                        st_reg <= CS_IDLE;
                    end
                end
                CS_RD: begin
                    if (!link.dq_mem_oe_n) begin
                        rdata_reg[4*beat_reg[2:0] +: 4] <= link.dq_mem;
                        beat_reg <= beat_reg + 4'h1;
                        if (beat_reg == (chop_reg ? 4'h3 : 4'h7)) begin
                            st_reg <= CS_IDLE;
                        end
                    end
                end
                CS_WR: begin
                    link.dq_ctl <= wdata_reg[4*beat_reg[2:0] +: 4];
                    link.dq_ctl_oe_n <= chop_reg && beat_reg[2];
                    beat_reg <= beat_reg + 4'h1;
                    if (beat_reg == 4'h7) begin
                        hold_reg <= 5'(sdm_pkg::wr_decode(mode_clean[11:9]));
                        st_reg <= CS_HOLD;
                    end
                end
                CS_SLEEP: begin
                    if (go && i_wdata[4]) begin
                        link.cke <= 1'b1;
                        hold_reg <= mode_reg[sdm_pkg::PD_BIT] ?
                            5'(sdm_pkg::XP_CYC) : 5'(sdm_pkg::XPDLL_CYC);
                        st_reg <= CS_HOLD;
                    end
                end
                default: st_reg <= CS_IDLE;
            endcase
        end
    end
endmodule : sdm_ctl

// [testbench/sdm_mz_props.sv]
// Concurrent checks on the controller-memory link
`timescale 1ns/1ns
module sdm_mz_props (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Link
    input wire logic cke,
    input wire logic [1:0] cmd,
    input wire logic [2:0] bank,
    input wire logic [18:0] addr,
    input wire logic dq_ctl_oe_n,
    input wire logic dq_mem_oe_n
);
    // ----------------------------------------
    // Lock wait counter
    // ----------------------------------------
    logic [9:0] lock_reg;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lock_reg <= 10'h000;
        end else if (cmd == sdm_pkg::CMD_MRS && addr[8]) begin
            lock_reg <= 10'h1ff;
        end else if (lock_reg != 10'h000) begin
            lock_reg <= lock_reg - 10'h001;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_mrs_rsv_zero: assert property (
        cmd == sdm_pkg::CMD_MRS |-> (addr & sdm_pkg::RSV_MASK) == 19'h00000)
        else $error("reserved mode bits set");
    a_mrs_wr_code: assert property (
        cmd == sdm_pkg::CMD_MRS |-> addr[11:9] == 3'h1)
        else $error("recovery code wrong");
    a_mrs_bank_zero: assert property (
        cmd == sdm_pkg::CMD_MRS |-> bank == 3'h0)
        else $error("mode set to wrong bank");
    a_mod_quiet: assert property (
        cmd == sdm_pkg::CMD_MRS |=> (cmd == sdm_pkg::CMD_NOP) [*8])
        else $error("command inside update time");
    a_lock_no_read: assert property (
        cmd == sdm_pkg::CMD_RD |-> lock_reg == 10'h000)
        else $error("read inside lock wait");
    a_lock_cke_high: assert property (
        lock_reg != 10'h000 |-> cke)
        else $error("clock enable low in lock wait");
    a_rd_first_gap: assert property (
        cmd == sdm_pkg::CMD_RD |=> dq_mem_oe_n [*4])
        else $error("read data too early");
    a_burst_min: assert property (
        $fell(dq_mem_oe_n) |-> (!dq_mem_oe_n) [*4])
        else $error("read burst too short");
    a_wr_drive: assert property (
        cmd == sdm_pkg::CMD_WR |=> (!dq_ctl_oe_n) [*4])
        else $error("write data not driven");
    a_sleep_quiet: assert property (
        !cke |-> cmd == sdm_pkg::CMD_NOP)
        else $error("command while asleep");
    a_wake_wait: assert property (
        $rose(cke) |-> (cmd == sdm_pkg::CMD_NOP) [*3])
        else $error("command inside exit time");
    a_no_fight: assert property (
        !(!dq_ctl_oe_n && !dq_mem_oe_n))
        else $error("both ends drive data");
endmodule : sdm_mz_props

// [testbench/sdm_mode_zero_burst_control_tb_top.sv]
// Testbench joining controller and memory ends
`timescale 1ns/1ns
`define CHK(a, b) do_chk((a) === (b))
module sdm_mode_zero_burst_control_tb_top;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [2:0] i_addr = 3'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic o_loop_locked, o_loop_running, o_interleaved;
    logic [3:0] o_read_latency, o_write_recovery;
    int error_cnt = 0;
    int num_checks = 0;
    int seed = 32'h2df71c3c;
    int lat_cnt = 0, lat_meas = 0, low_cnt = 0, burst_len = 0;
    logic oe_prev = 1'b1;
    logic z_seen = 1'b0;
    logic [3:0] mdl [64];
    logic [31:0] v, d, r;
    sdm_link_if lk ();
    sdm_ctl i_sdm_ctl (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .link(lk));
    sdm_mem #(.COL_W(6)) i_sdm_mem (.i_clk(i_clk), .i_rst(i_rst), .link(lk),
        .o_loop_locked(o_loop_locked), .o_loop_running(o_loop_running),
        .o_read_latency(o_read_latency), .o_write_recovery(o_write_recovery),
        .o_interleaved(o_interleaved));
    sdm_mz_props i_sdm_mz_props (.i_clk(i_clk), .i_rst(i_rst), .cke(lk.cke), .cmd(lk.cmd),
        .bank(lk.bank), .addr(lk.addr), .dq_ctl_oe_n(lk.dq_ctl_oe_n),
        .dq_mem_oe_n(lk.dq_mem_oe_n));
    always #20 i_clk = ~i_clk;
    // ----------------------------------------
    // Wire monitor: latency, burst length, release
    // ----------------------------------------
    always @(posedge i_clk) begin
        lat_cnt <= (lk.cmd == sdm_pkg::CMD_RD) ? 0 : lat_cnt + 1;
        oe_prev <= lk.dq_mem_oe_n;
        low_cnt <= lk.dq_mem_oe_n ? 0 : low_cnt + 1;
        if (oe_prev && !lk.dq_mem_oe_n) lat_meas <= lat_cnt;
        if (lk.dq_mem_oe_n && !oe_prev) begin
            burst_len <= low_cnt;
            z_seen <= (lk.dqs_mem_oe_n === 1'b1);
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic do_chk(input bit ok);
        num_checks++;
        if (!ok) begin
            error_cnt++;
            $display("MISMATCH %0t value differs", $time);
        end
    endtask : do_chk
    task automatic reg_wr(input logic [2:0] a, input logic [31:0] dat);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= dat;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [2:0] a, output logic [31:0] dat);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        dat = o_rdata;
    endtask : reg_rd
    task automatic wait_idle;
        for (int n = 0; n < 300; n++) begin
            reg_rd(sdm_pkg::REG_CTRL, v);
            if (v[0] === 1'b0) return;
        end
        do_chk(1'b0);
    endtask : wait_idle
    function automatic logic [31:0] exp_rd(input logic [5:0] c, input logic bt);
        logic [2:0] lo;
        logic [31:0] e;
        e = 32'h0;
        for (int k = 0; k < 8; k++) begin
            lo = bt ? (c[2:0] ^ k[2:0]) : {c[2] ^ k[2], c[1:0] + k[1:0]};
            e[4*k+:4] = mdl[{c[5:3], lo}];
        end
        return e;
    endfunction : exp_rd
    task automatic set_mode(input logic [1:0] bl, input logic bt, input int lat,
        input logic lock, input logic pd);
        logic [3:0] c;
        logic [31:0] w;
        c = (lat < 12) ? 4'((lat - 4) * 2) : 4'((lat - 12) * 2 + 1);
        w = {19'h0, pd, 3'h6, lock, 1'b0, c[3:1], bt, c[0], bl} | {13'h0, sdm_pkg::RSV_MASK};
        reg_wr(sdm_pkg::REG_MODE, w);
        reg_wr(sdm_pkg::REG_CTRL, 32'h1);
        wait_idle;
        reg_rd(sdm_pkg::REG_MODE, v);
        `CHK(v, w);
        `CHK(o_read_latency, 4'(lat));
        `CHK(o_interleaved, bt);
        `CHK(o_write_recovery, 4'h5);
    endtask : set_mode
    task automatic burst(input logic wr, input logic [5:0] c, input logic a12,
        input logic [1:0] bl, input logic bt, input int lat);
        logic chop;
        logic [31:0] m, e;
        chop = (bl == sdm_pkg::BL_CHOP4) || (bl == sdm_pkg::BL_OTF && !a12);
        m = chop ? 32'h0000ffff : 32'hffffffff;
        reg_wr(sdm_pkg::REG_ADDR, {19'h0, a12, 6'h0, c});
        if (wr) begin
            d = $random(seed);
            reg_wr(sdm_pkg::REG_WDATA, d);
            reg_wr(sdm_pkg::REG_CTRL, 32'h4);
            for (int k = 0; k < 8; k++) begin
                if (chop && k < 4) mdl[{c[5:2], k[1:0]}] = d[4*k+:4];
                if (!chop) mdl[{c[5:3], k[2:0]}] = d[4*k+:4];
            end
            wait_idle;
        end else begin
            e = exp_rd(c, bt);
            reg_wr(sdm_pkg::REG_CTRL, 32'h2);
            wait_idle;
            reg_rd(sdm_pkg::REG_RDATA, v);
            `CHK(v & m, e & m);
            `CHK(lat_meas, lat);
            `CHK(burst_len, chop ? 4 : 8);
            `CHK(z_seen, 1'b1);
        end
    endtask : burst
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        `CHK(o_read_latency, 4'h5);
        `CHK(o_loop_locked, 1'b1);
        for (int a = 5; a < 8; a++) begin
            reg_rd(3'(a), v);
            `CHK(v, 32'h0);
        end
        $display("test reset done");
        set_mode(sdm_pkg::BL_FIXED8, 1'b0, 5, 1'b1, 1'b1);
        reg_rd(sdm_pkg::REG_CTRL, v);
        `CHK(v[2], 1'b1);
        `CHK(o_loop_locked, 1'b0);
        reg_wr(sdm_pkg::REG_CTRL, 32'h2);
        reg_rd(sdm_pkg::REG_CTRL, v);
        `CHK(v[0], 1'b0);
        repeat (520) @(posedge i_clk);
        reg_rd(sdm_pkg::REG_CTRL, v);
        `CHK(v[2], 1'b0);
        `CHK(o_loop_locked, 1'b1);
        $display("test lock done");
        for (int b = 0; b < 8; b++) burst(1'b1, 6'(b * 8), 1'b1, sdm_pkg::BL_FIXED8, 1'b0, 5);
        for (int n = 0; n < 40; n++) begin
            r = $random(seed);
            set_mode(2'(n % 4), r[0], 5 + n % 10, 1'b0, 1'b1);
            burst(r[1], r[7:2], r[8], 2'(n % 4), r[0], 5 + n % 10);
            burst(1'b0, r[14:9], r[15], 2'(n % 4), r[0], 5 + n % 10);
        end
        $display("test bursts done");
        for (int p = 0; p < 2; p++) begin
            set_mode(sdm_pkg::BL_FIXED8, 1'b0, 6, 1'b0, p[0]);
            reg_wr(sdm_pkg::REG_CTRL, 32'h8);
            reg_rd(sdm_pkg::REG_CTRL, v);
            `CHK(v[1], 1'b1);
            `CHK(lk.cke, 1'b0);
            `CHK(o_loop_running, p[0]);
            reg_wr(sdm_pkg::REG_CTRL, 32'h10);
            wait_idle;
            repeat (12) @(posedge i_clk);
            `CHK(o_loop_running, 1'b1);
            `CHK(o_loop_locked, 1'b1);
            burst(1'b0, 6'h15, 1'b1, sdm_pkg::BL_FIXED8, 1'b0, 6);
        end
        $display("test sleep done");
        wrap_up;
    end
    initial begin
        repeat (30000) @(posedge i_clk);
        error_cnt++;
        wrap_up;
    end
endmodule : sdm_mode_zero_burst_control_tb_top
